/* File: rtl/ami_pkg.sv */
// Summary of operation
// R1 - Address pins carry the external access address, or serve as flag lines 15 to 8 or as pulse-width outputs.
// R2 - After reset every address pin is in external memory mode and flag pins 0 to 3 are flags.
// R3 - When the parallel input configuration selects it, input channel 0 samples address pins 23 to 4.
// R4 - The 16-bit data bus serves as bidirectional memory data or as flag lines 7 to 0.
// R5 - An access is not completed while the acknowledge input is held low by the external device.
// R6 - Bank selects 0 and 1 are active low chip selects of their external banks.
// R7 - Bank selects are decoded from the access address and change together with the address.
// R8 - Bank selects are inactive when no access runs, and a true conditional access still asserts them.
// R9 - Bank select 1 also selects the boot device in external port boot mode.
// R10 - The read strobe is asserted on every word read from external memory.
// R11 - The write strobe is asserted on every word write to external memory.
// R12 - Flag pin 2 can serve as flag, interrupt request 2 input, or bank select 2 in the large package.
// R13 - Flag pin 3 can serve as flag, timer expired output, or bank select 3 in the large package.
// R14 - Strobes are active low, never together, and only while a bank select is active.
package ami_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int BANK_W = 4;
    localparam int BANK_LSB = 22;
    localparam int PWM_W = 8;
    localparam int IDP_LSB = 4;
    localparam int IDP_W = 20;
    localparam int FLAG_HI_LSB = 8;
    localparam int FLAG_W = 16;
    localparam logic [1:0] ADDR_MODE_EXT_MEMORY_IFACE_MODE = 2'h0;
    localparam logic [1:0] ADDR_MODE_FLAG = 2'h1;
    localparam logic [1:0] ADDR_MODE_PWM = 2'h2;
    localparam logic [1:0] PIN_MODE_FLAG = 2'h0;
    localparam logic [1:0] PIN_MODE_ALT = 2'h1;
    localparam logic [1:0] PIN_MODE_BANK = 2'h2;

    typedef enum logic [1:0] {
        AMI_IDLE = 2'b00,
        AMI_STROBE = 2'b01,
        AMI_DONE = 2'b10
    } ami_state_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ami_req_type;

    typedef struct packed {
        logic [1:0] addr_mode;
        logic data_flag_mode;
        logic idp_enable;
        logic boot_external_port_boot;
        logic [1:0] pin2_mode;
        logic [1:0] pin3_mode;
        logic large_package;
    } ami_cfg_type;
endpackage : ami_pkg

/* File: rtl/ami_pin_iface.sv */
`timescale 1ns/1ns
module ami_pin_iface
    import ami_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic RESETN_I,
    // Core side
    input wire ami_req_type REQ_I,
    output logic REQ_READY_O,
    output logic RDATA_VALID_O,
    output logic [DATA_W-1:0] RDATA_O,
    input wire ami_cfg_type CFG_I,
    input wire logic [FLAG_W-1:0] FLAG_OUT_I,
    input wire logic [FLAG_W-1:0] FLAG_OE_I,
    output logic [FLAG_W-1:0] FLAG_IN_O,
    input wire logic [PWM_W-1:0] PWM_I,
    input wire logic TIMER_EXPIRED_I,
    output logic IRQ2_O,
    output logic IDP_VALID_O,
    output logic [IDP_W-1:0] IDP_DATA_O,
    // Pins
    output logic [ADDR_W-1:0] ADDR_O,
    output logic [ADDR_W-1:0] ADDR_OE_N_O,
    input wire logic [ADDR_W-1:0] ADDR_I,
    output logic [DATA_W-1:0] DATA_O,
    output logic [DATA_W-1:0] DATA_OE_N_O,
    input wire logic [DATA_W-1:0] DATA_I,
    input wire logic MEM_ACKNOWLEDGE_IN_I,
    output logic [1:0] BANK_SELECT_N_O,
    output logic READ_STROBE_N_O,
    output logic WRITE_STROBE_N_O,
    output logic FLAG_PIN_TWO_O,
    output logic FLAG_PIN_TWO_OE_N_O,
    input wire logic FLAG_PIN_TWO_I,
    output logic FLAG_PIN_THREE_O,
    output logic FLAG_PIN_THREE_OE_N_O,
    input wire logic FLAG_PIN_THREE_I
);
    logic [1:0] rst_sync;
    logic rst_n;
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'h1};
        end
    end
    assign rst_n = rst_sync[1];

    // Pin inputs pass two flops before use; stage one feeds only stage two.
    localparam int SYNC_W = ADDR_W + DATA_W + 3;
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= '1;
            sync_b <= '1;
        end else begin
            sync_a <= {ADDR_I, DATA_I, MEM_ACKNOWLEDGE_IN_I, FLAG_PIN_TWO_I, FLAG_PIN_THREE_I};
            sync_b <= sync_a;
        end
    end
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] data_s;
    logic ack_s;
    logic pin2_s;
    logic pin3_s;
    assign {addr_s, data_s, ack_s, pin2_s, pin3_s} = sync_b;

    ami_state_type state;
    ami_state_type next_state;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] next_addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] next_wdata;
    logic write;
    logic next_write;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] next_rdata;
    logic rvalid;
    logic next_rvalid;
    logic [BANK_W-1:0] bank_n;
    logic [BANK_W-1:0] next_bank_n;
    logic rd_n;
    logic next_rd_n;
    logic wr_n;
    logic next_wr_n;
    logic idp_valid;
    logic next_idp_valid;
    logic [IDP_W-1:0] idp_data;
    logic [IDP_W-1:0] next_idp_data;
    // Acknowledge and read data reach the state machine three edges after the pins move,
    // so the strobe is held that long before the acknowledge is trusted.
    localparam logic [1:0] ACK_SETTLE = 2'h2;
    logic [1:0] settle;
    logic [1:0] next_settle;

    always_comb begin
        next_state = state;
        next_addr = addr;
        next_wdata = wdata;
        next_write = write;
        next_rdata = rdata;
        next_rvalid = 1'h0;
        next_bank_n = bank_n;
        next_rd_n = rd_n;
        next_wr_n = wr_n;
        next_settle = settle;
        case (state)
            AMI_IDLE: begin
                // A conditional access that passes arrives here as a valid request.
                if (REQ_I.valid) begin // R8
                    next_addr = REQ_I.addr;
                    next_wdata = REQ_I.wdata;
                    next_write = REQ_I.write;
                    next_bank_n = '1;
                    // One-hot decode of the top address bits, loaded with the address.
                    next_bank_n[REQ_I.addr[BANK_LSB +: 2]] = 1'h0; // R6 R7
                    if (CFG_I.boot_external_port_boot) begin
                        next_bank_n = 4'hD; // R9
                    end
                    next_rd_n = REQ_I.write; // R10 R14
                    next_wr_n = !REQ_I.write; // R11 R14
                    next_settle = '0;
                    next_state = AMI_STROBE;
                end
            end
            AMI_STROBE: begin
                // The synchronised acknowledge is only trusted once it reflects the pins
                // under the strobe; from then on the strobe is held while it is low.
                if (settle != ACK_SETTLE) begin
                    next_settle = settle + 2'h1;
                end else if (ack_s) begin // R5
                    next_rdata = data_s;
                    next_rvalid = !write; // R10
                    next_rd_n = 1'h1;
                    next_wr_n = 1'h1;
                    next_state = AMI_DONE;
                end
            end
            AMI_DONE: begin
                // Selects drop one cycle after the strobes so strobes sit inside selects.
                next_bank_n = '1; // R8 R14
                next_state = AMI_IDLE;
            end
            default: begin
                next_bank_n = '1;
                next_rd_n = 1'h1;
                next_wr_n = 1'h1;
                next_state = AMI_IDLE;
            end
        endcase
    end

    always_comb begin
        next_idp_valid = CFG_I.idp_enable; // R3
        next_idp_data = CFG_I.idp_enable ? addr_s[IDP_LSB +: IDP_W] : idp_data; // R3
    end

    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            state <= AMI_IDLE;
            addr <= '0;
            wdata <= '0;
            write <= 1'h0;
            rdata <= '0;
            rvalid <= 1'h0;
            bank_n <= '1;
            rd_n <= 1'h1;
            wr_n <= 1'h1;
            idp_valid <= 1'h0;
            idp_data <= '0;
            settle <= '0;
        end else begin
            state <= next_state;
            addr <= next_addr;
            wdata <= next_wdata;
            write <= next_write;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
            bank_n <= next_bank_n;
            rd_n <= next_rd_n;
            wr_n <= next_wr_n;
            idp_valid <= next_idp_valid;
            idp_data <= next_idp_data;
            settle <= next_settle;
        end
    end

    logic in_access;
    assign in_access = (state != AMI_IDLE);
    assign REQ_READY_O = (state == AMI_IDLE);
    assign RDATA_VALID_O = rvalid;
    assign RDATA_O = rdata;
    assign IDP_VALID_O = idp_valid;
    assign IDP_DATA_O = idp_data;
    assign BANK_SELECT_N_O = bank_n[1:0]; // R6
    assign READ_STROBE_N_O = rd_n; // R10
    assign WRITE_STROBE_N_O = wr_n; // R11

    // Address pins; the mode config resets to memory mode in the core. The input channel
    // takes the pins as inputs, so it releases the drive of every pin but flag lines 15 to 8 in flag mode.
    always_comb begin
        ADDR_O = addr;
        ADDR_OE_N_O = CFG_I.idp_enable ? '1 : '0; // R2 R3
        case (CFG_I.addr_mode)
            ADDR_MODE_FLAG: begin // R1
                ADDR_O[FLAG_HI_LSB +: 8] = FLAG_OUT_I[FLAG_HI_LSB +: 8];
                ADDR_OE_N_O[FLAG_HI_LSB +: 8] = ~FLAG_OE_I[FLAG_HI_LSB +: 8];
            end
            ADDR_MODE_PWM: begin // R1
                ADDR_O[PWM_W-1:0] = PWM_I;
            end
            default: begin
            end
        endcase
    end

    // Data bus drives during a write access in memory mode, and on enabled flag lines 7 to 0 in flag mode.
    always_comb begin
        if (CFG_I.data_flag_mode) begin // R4
            DATA_O = {8'h00, FLAG_OUT_I[7:0]};
            DATA_OE_N_O = {8'hFF, ~FLAG_OE_I[7:0]};
        end else begin
            DATA_O = wdata;
            DATA_OE_N_O = (in_access && write) ? '0 : '1; // R4
        end
    end

    always_comb begin
        FLAG_IN_O = {addr_s[FLAG_HI_LSB +: 8], data_s[7:0]};
        FLAG_IN_O[2] = pin2_s;
        FLAG_IN_O[3] = pin3_s;
        IRQ2_O = (CFG_I.pin2_mode == PIN_MODE_ALT) && !pin2_s; // R12
        FLAG_PIN_TWO_O = FLAG_OUT_I[2];
        FLAG_PIN_TWO_OE_N_O = !FLAG_OE_I[2]; // R2
        FLAG_PIN_THREE_O = FLAG_OUT_I[3];
        FLAG_PIN_THREE_OE_N_O = !FLAG_OE_I[3]; // R2
        if (CFG_I.pin2_mode == PIN_MODE_ALT) begin
            FLAG_PIN_TWO_OE_N_O = 1'h1; // R12
        end else if (CFG_I.pin2_mode == PIN_MODE_BANK && CFG_I.large_package) begin
            FLAG_PIN_TWO_O = bank_n[2]; // R12
            FLAG_PIN_TWO_OE_N_O = 1'h0;
        end
        if (CFG_I.pin3_mode == PIN_MODE_ALT) begin
            FLAG_PIN_THREE_O = TIMER_EXPIRED_I; // R13
            FLAG_PIN_THREE_OE_N_O = 1'h0;
        end else if (CFG_I.pin3_mode == PIN_MODE_BANK && CFG_I.large_package) begin
            FLAG_PIN_THREE_O = bank_n[3]; // R13
            FLAG_PIN_THREE_OE_N_O = 1'h0;
        end
    end
endmodule : ami_pin_iface

/* File: test/ami_pin_chk.sv */
`timescale 1ns/1ns
module ami_pin_chk
    import ami_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic RESETN_I,
    // Observed ports
    input wire ami_req_type REQ_I,
    input wire logic REQ_READY_O,
    input wire logic RDATA_VALID_O,
    input wire ami_cfg_type CFG_I,
    input wire logic [ADDR_W-1:0] ADDR_O,
    input wire logic [ADDR_W-1:0] ADDR_OE_N_O,
    input wire logic [DATA_W-1:0] DATA_OE_N_O,
    input wire logic MEM_ACKNOWLEDGE_IN_I,
    input wire logic [1:0] BANK_SELECT_N_O,
    input wire logic READ_STROBE_N_O,
    input wire logic WRITE_STROBE_N_O,
    input wire logic FLAG_PIN_TWO_O,
    input wire logic FLAG_PIN_TWO_OE_N_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESETN_I);
    wire logic strobe = !READ_STROBE_N_O || !WRITE_STROBE_N_O;
    // Banks 2 and 3 live on shared pins, so the strobe and tail select checks cover only the two dedicated selects.
    wire logic low_bank = !ADDR_O[23] && !CFG_I.boot_external_port_boot;

    chk_strobe_excl: assert property (!(!READ_STROBE_N_O && !WRITE_STROBE_N_O))
        else $error("read and write strobes low together");
    chk_strobe_bank: assert property (strobe && low_bank |->
        BANK_SELECT_N_O == ~(2'h1 << ADDR_O[22])) else $error("bank select wrong under strobe");
    chk_take_read: assert property (REQ_I.valid && REQ_READY_O && !REQ_I.write |=>
        !READ_STROBE_N_O && ADDR_O == $past(REQ_I.addr)) else $error("read not started");
    chk_take_write: assert property (REQ_I.valid && REQ_READY_O && REQ_I.write |=>
        !WRITE_STROBE_N_O && DATA_OE_N_O == '0) else $error("write not started");
    // Acknowledge passes two sync stages, so a low seen two edges back still holds the strobe.
    chk_ack_hold: assert property (strobe && $past(MEM_ACKNOWLEDGE_IN_I, 2) == 1'b0 |=> strobe)
        else $error("strobe released during wait");
    chk_idle_quiet: assert property (REQ_READY_O |-> BANK_SELECT_N_O == 2'h3 && !strobe)
        else $error("select or strobe active while idle");
    chk_read_done: assert property ($rose(READ_STROBE_N_O) |-> RDATA_VALID_O)
        else $error("read data not delivered at strobe end");
    chk_bank_tail: assert property ($rose(READ_STROBE_N_O) && low_bank |->
        BANK_SELECT_N_O != 2'h3 ##1 BANK_SELECT_N_O == 2'h3) else $error("bank select tail");
    chk_addr_ext_memory_iface_mode: assert property (CFG_I.addr_mode == ADDR_MODE_EXT_MEMORY_IFACE_MODE && !CFG_I.idp_enable
        |-> ADDR_OE_N_O == '0) else $error("address pins not driven");
    chk_boot_bank: assert property (strobe && CFG_I.boot_external_port_boot |-> BANK_SELECT_N_O == 2'h1)
        else $error("boot select not on bank one");
    chk_bank_two: assert property (strobe && CFG_I.large_package &&
        CFG_I.pin2_mode == PIN_MODE_BANK |-> !FLAG_PIN_TWO_OE_N_O &&
        FLAG_PIN_TWO_O == (ADDR_O[23:22] != 2'h2)) else $error("shared pin two select wrong");
endmodule : ami_pin_chk

bind ami_pin_iface ami_pin_chk u_chk (.CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I), .REQ_I(REQ_I),
    .REQ_READY_O(REQ_READY_O), .RDATA_VALID_O(RDATA_VALID_O), .CFG_I(CFG_I), .ADDR_O(ADDR_O),
    .ADDR_OE_N_O(ADDR_OE_N_O), .DATA_OE_N_O(DATA_OE_N_O), .BANK_SELECT_N_O(BANK_SELECT_N_O),
    .MEM_ACKNOWLEDGE_IN_I(MEM_ACKNOWLEDGE_IN_I), .READ_STROBE_N_O(READ_STROBE_N_O),
    .WRITE_STROBE_N_O(WRITE_STROBE_N_O), .FLAG_PIN_TWO_O(FLAG_PIN_TWO_O),
    .FLAG_PIN_TWO_OE_N_O(FLAG_PIN_TWO_OE_N_O));

/* File: test/ami_mem_model.sv */
`timescale 1ns/1ns
module ami_mem_model
    import ami_pkg::*;
(
    input wire logic clk_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic [3:0] wait_i,
    output logic ack_o,
    output logic [DATA_W-1:0] data_o
);
    logic [DATA_W-1:0] mem [256];
    logic [3:0] cnt = 4'h0;
    always @(posedge clk_i) begin
        cnt <= (rd_n_i && wr_n_i) ? 4'h0 : cnt + 4'h1;
        if (!wr_n_i && ack_o) mem[addr_i[7:0]] <= data_i;
    end
    // Acknowledge stays low for the first wait_i cycles of each strobe.
    assign ack_o = (rd_n_i && wr_n_i) || cnt >= wait_i;
    // Released data lines float to the pull-up level.
    assign data_o = rd_n_i ? '1 : mem[addr_i[7:0]];
endmodule : ami_mem_model

/* File: test/tb.sv */
`timescale 1ns/1ns
module tb;
    import ami_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, tmr = 1'b0, ext2 = 1'b1;
    logic rdy, rvld, ivld, rd_n, wr_n, ack, f2, f2_oe_n, f3, f3_oe_n, irq2;
    logic [3:0] wait_n = 4'h0;
    logic [PWM_W-1:0] pwm = '0;
    logic [FLAG_W-1:0] fl_out = '0, fl_oe = '0, flin;
    logic [DATA_W-1:0] rdata, data_o, data_oe_n, din, mem [256];
    logic [ADDR_W-1:0] addr_o, addr_oe_n, idp_pat = '0, al [16];
    logic [IDP_W-1:0] idata;
    logic [DATA_W-1:0] expq [$];
    ami_req_type req = '0;
    ami_cfg_type cfg = '0;
    int n_errors = 0, checks_done = 0, cycles = 0, seed;
    wire logic [ADDR_W-1:0] addr_w = (addr_oe_n & idp_pat) | (~addr_oe_n & addr_o);
    wire logic [DATA_W-1:0] data_w = (data_oe_n & din) | (~data_oe_n & data_o);

    ami_pin_iface u_dut (.CLOCK_I(clk), .RESETN_I(rst_n), .REQ_I(req), .REQ_READY_O(rdy),
        .RDATA_VALID_O(rvld), .RDATA_O(rdata), .CFG_I(cfg), .FLAG_OUT_I(fl_out),
        .FLAG_OE_I(fl_oe), .FLAG_IN_O(flin), .PWM_I(pwm), .TIMER_EXPIRED_I(tmr), .IRQ2_O(irq2),
        .IDP_VALID_O(ivld), .IDP_DATA_O(idata), .ADDR_O(addr_o), .ADDR_OE_N_O(addr_oe_n),
        .ADDR_I(addr_w), .DATA_O(data_o), .DATA_OE_N_O(data_oe_n), .DATA_I(data_w),
        .MEM_ACKNOWLEDGE_IN_I(ack), .BANK_SELECT_N_O(), .READ_STROBE_N_O(rd_n),
        .WRITE_STROBE_N_O(wr_n), .FLAG_PIN_TWO_O(f2), .FLAG_PIN_TWO_OE_N_O(f2_oe_n),
        .FLAG_PIN_TWO_I(f2_oe_n ? ext2 : f2), .FLAG_PIN_THREE_O(f3),
        .FLAG_PIN_THREE_OE_N_O(f3_oe_n),
        .FLAG_PIN_THREE_I(f3 | f3_oe_n));
    ami_mem_model u_mem (.clk_i(clk), .rd_n_i(rd_n), .wr_n_i(wr_n), .addr_i(addr_o),
        .data_i(data_w), .wait_i(wait_n), .ack_o(ack), .data_o(din));

    always #5 clk = ~clk;

    task automatic fail(input string m);
        n_errors++;
        $display("MISMATCH %0t %s", $time, m);
    endtask : fail

    task automatic check_rd(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (got !== exp) fail("read data");
    endtask : check_rd

    task automatic check_idp(input logic v, input logic [IDP_W-1:0] got, exp);
        checks_done++;
        if (v !== 1'b1 || got !== exp) fail("input port data");
    endtask : check_idp

    task automatic check_pin(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
        checks_done++;
        if (got !== exp) fail("pin level");
    endtask : check_pin

    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    // The request is held until the edge that samples ready high takes it.
    task automatic op(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        #1;
        req = '{1'b1, w, a, d};
        while (rdy !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        wait_n = 4'($urandom_range(5, 0));
        @(posedge clk);
        #1;
        req.valid = 1'b0;
        if (w) mem[a[7:0]] = d;
        else expq.push_back(mem[a[7:0]]);
    endtask : op

    always @(posedge clk) begin
        if (rvld === 1'b1) begin
            if (expq.size() == 0) fail("unexpected read data");
            else check_rd(rdata, expq.pop_front());
        end
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail("timeout");
            summarize();
        end
    end

    initial begin
        seed = $urandom(32'hF5EB6D61);
        {fl_out, fl_oe, pwm, tmr} = 41'($urandom);
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        for (int k = 0; k < 16; k++) begin
            al[k] = {1'b0, 23'($urandom)};
            op(1'b1, al[k], 16'($urandom));
            op(1'b0, al[k], '0);
        end
        for (int k = 0; k < 16; k++) op(1'b0, al[k], '0);
        repeat (8) @(posedge clk);
        #1;
        if (expq.size() != 0) fail("reads not answered");
        idp_pat = 24'($urandom);
        cfg.idp_enable = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        check_idp(ivld, idata, idp_pat[ADDR_W-1:IDP_LSB]);
        cfg = '0;
        cfg.boot_external_port_boot = 1'b1;
        op(1'b0, al[0], '0);
        repeat (12) @(posedge clk);
        #1;
        cfg = '{ADDR_MODE_EXT_MEMORY_IFACE_MODE, 1'b0, 1'b0, 1'b0, PIN_MODE_BANK, PIN_MODE_FLAG, 1'b1};
        op(1'b0, {2'h2, al[1][21:0]}, '0);
        repeat (12) @(posedge clk);
        #1;
        cfg = '{ADDR_MODE_FLAG, 1'b1, 1'b0, 1'b0, PIN_MODE_ALT, PIN_MODE_ALT, 1'b0};
        ext2 = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check_pin(addr_o[15:8], fl_out[15:8]);
        check_pin(addr_oe_n[15:8], 8'(~fl_oe[15:8]));
        check_pin(data_o[7:0], fl_out[7:0]);
        check_pin(data_oe_n, {8'hFF, ~fl_oe[7:0]});
        check_pin({f3, f3_oe_n, f2_oe_n, irq2}, {tmr, 3'h3});
        check_pin(flin[3:2], {tmr, 1'b0});
        cfg.addr_mode = ADDR_MODE_PWM;
        #1;
        check_pin(addr_o[PWM_W-1:0], pwm);
        if (expq.size() != 0) fail("reads not answered");
        summarize();
    end
endmodule : tb
